// *** design/magreg_pkg.sv ***
package magreg_pkg;

	// ------------------------------------------------------------
	// register space geometry
	// ------------------------------------------------------------
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned ADDR_W     = 8;
	localparam logic [7:0]  ADDR_FIRST = 8'h40;
	localparam logic [7:0]  ADDR_LAST  = 8'h71;
	localparam int unsigned ADDR_COUNT = 50;

	// ------------------------------------------------------------
	// read-only range
	// ------------------------------------------------------------
	localparam logic [7:0]  RO_LAST     = 8'h4A;
	localparam logic [7:0]  ID_ADDR     = 8'h40;
	localparam logic [7:0]  ID_RSVD     = 8'h41;
	localparam logic [7:0]  STATUS_BASE = 8'h42;
	localparam int unsigned STATUS_NUM  = 9;
	// arbitrary identification value
	localparam logic [7:0]  DEVICE_ID   = 8'hA5;

	// ------------------------------------------------------------
	// writable range 0x4B .. 0x52
	// ------------------------------------------------------------
	localparam logic [7:0]  RW_BASE = 8'h4B;
	localparam int unsigned RW_NUM  = 8;
	localparam logic [7:0]  XY_REP_ADDR = 8'h51;
	localparam logic [7:0]  Z_REP_ADDR  = 8'h52;
	localparam int unsigned XY_REP_IDX  = 6;
	localparam int unsigned Z_REP_IDX   = 7;
	localparam logic [7:0]  XY_REP_RESET = 8'h00;
	localparam logic [7:0]  Z_REP_RESET  = 8'h00;

	// reset values, index 0 in the low byte (0x4B .. 0x52)
	localparam logic [63:0] RW_RESETS = {Z_REP_RESET, XY_REP_RESET, 8'h00, 8'h00,
		8'h07, 8'h3F, 8'h06, 8'h01};
	// writable bits; zero marks a reserved or fixed bit
	localparam logic [63:0] RW_MASKS  = {8'hFF, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'h87};

	// ------------------------------------------------------------
	// reserved tail
	// ------------------------------------------------------------
	localparam logic [7:0]  RSVD_FIRST = 8'h53;
	localparam logic [7:0]  READ_FILL  = 8'h00;

	typedef enum {
		CLS_ID,
		CLS_STATUS,
		CLS_RW,
		CLS_RSVD,
		CLS_NONE
	} addr_class_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic              valid;
		logic              drive;
		logic [DATA_W-1:0] data;
	} reg_rsp_t;

	function automatic addr_class_t classify(input logic [7:0] a);
		if (a < ADDR_FIRST || a > ADDR_LAST)
			return CLS_NONE;
		else if (a == ID_ADDR)
			return CLS_ID;
		else if (a == ID_RSVD)
			return CLS_RSVD;
		else if (a <= RO_LAST)
			return CLS_STATUS;
		else if (a < RSVD_FIRST)
			return CLS_RW;
		else
			return CLS_RSVD;
	endfunction

endpackage

// *** design/config_byte.sv ***
`timescale 1ns/1ps
// one writable byte; bits outside the mask never store anything
module config_byte #(
	parameter logic [7:0] RESET_VAL = 8'h00,
	parameter logic [7:0] WR_MASK   = 8'hFF
) (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       we,
	input  wire logic [7:0] wdata,
	output logic      [7:0] value_q
);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			value_q <= RESET_VAL;
		end else if (we) begin
			value_q <= (wdata & WR_MASK) | (RESET_VAL & ~WR_MASK); // RQ3
		end
	end

endmodule

// *** design/magnetometer_register_space.sv ***
`timescale 1ns/1ps

// Summary of operation
// [RQ1] every register is one byte wide
// [RQ2] decode 50 addresses, 0x40 through 0x71
// [RQ3] writes drop values of reserved bits
// [RQ4] host ignores reserved read contents
// [RQ5] reserved reads may leave data undriven
// [RQ6] 0x40 to 0x4A read-only, writes dropped
// [RQ7] 0x52 holds Z repetition count, reset 0x00
// [RQ8] 0x53 to 0x71 reserved, no content
// [RQ9] 0x51 holds XY repetition count, reset 0x00
// [RQ10] reserved writes change nothing anywhere; wr_done_q still pulses for them
module magnetometer_register_space #(
	parameter int unsigned STATUS_BYTES = magreg_pkg::STATUS_NUM
) (
	input  wire logic                               clk,
	input  wire logic                               nrst,
	input  wire magreg_pkg::reg_req_t               req,
	input  wire logic [STATUS_BYTES*8-1:0]          status_bytes,
	output magreg_pkg::reg_rsp_t                    rsp_q,
	output logic                                    wr_done_q,
	output logic                                    wr_taken_q,
	output logic [magreg_pkg::RW_NUM*8-1:0]         config_bytes,
	output logic [magreg_pkg::DATA_W-1:0]           xy_repetition_count,
	output logic [magreg_pkg::DATA_W-1:0]           z_repetition_count
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	magreg_pkg::addr_class_t cls;
	logic [7:0]              rw_off;
	logic [7:0]              st_off;
	logic [magreg_pkg::RW_NUM-1:0] rw_we;

	assign cls    = magreg_pkg::classify(req.addr); // RQ2
	assign rw_off = req.addr - magreg_pkg::RW_BASE;
	assign st_off = req.addr - magreg_pkg::STATUS_BASE;

	// only the writable window produces a strobe; read-only and
	// reserved writes fall through and store nothing; only wr_done_q answers them
	always_comb begin
		rw_we = '0;
		if (req.wr && cls == magreg_pkg::CLS_RW) begin // RQ6 RQ10
			rw_we[rw_off[2:0]] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// writable bytes
	// ------------------------------------------------------------
	// one instance per writable byte, named by function so a probe finds it;
	// the store strobe comes only from the decode above, never from the address alone
	// 0x4B power and reset control; bits 6:3 are fixed and never store,
	// so a host write of all ones reads back with only the live bits set
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[0 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[0 +: 8])
	) u_power_ctrl (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[0]),
		.wdata   (req.wdata),
		.value_q (config_bytes[0 +: 8])
	); // RQ1 RQ3

	// 0x4C operating mode, output rate and self-test
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[8 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[8 +: 8])
	) u_op_ctrl (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[1]),
		.wdata   (req.wdata),
		.value_q (config_bytes[8 +: 8])
	); // RQ1 RQ3

	// 0x4D interrupt enables
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[16 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[16 +: 8])
	) u_int_enables (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[2]),
		.wdata   (req.wdata),
		.value_q (config_bytes[16 +: 8])
	); // RQ1 RQ3

	// 0x4E interrupt pin and axis control
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[24 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[24 +: 8])
	) u_int_ctrl (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[3]),
		.wdata   (req.wdata),
		.value_q (config_bytes[24 +: 8])
	); // RQ1 RQ3

	// 0x4F low threshold
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[32 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[32 +: 8])
	) u_low_limit (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[4]),
		.wdata   (req.wdata),
		.value_q (config_bytes[32 +: 8])
	); // RQ1 RQ3

	// 0x50 high threshold
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[40 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[40 +: 8])
	) u_high_limit (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[5]),
		.wdata   (req.wdata),
		.value_q (config_bytes[40 +: 8])
	); // RQ1 RQ3

	// 0x51 xy repetition count
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[magreg_pkg::XY_REP_IDX*8 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[magreg_pkg::XY_REP_IDX*8 +: 8])
	) u_xy_reps (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[magreg_pkg::XY_REP_IDX]),
		.wdata   (req.wdata),
		.value_q (config_bytes[magreg_pkg::XY_REP_IDX*8 +: 8])
	); // RQ1 RQ9

	// 0x52 z repetition count
	config_byte #(
		.RESET_VAL (magreg_pkg::RW_RESETS[magreg_pkg::Z_REP_IDX*8 +: 8]),
		.WR_MASK   (magreg_pkg::RW_MASKS[magreg_pkg::Z_REP_IDX*8 +: 8])
	) u_z_reps (
		.clk     (clk),
		.nrst    (nrst),
		.we      (rw_we[magreg_pkg::Z_REP_IDX]),
		.wdata   (req.wdata),
		.value_q (config_bytes[magreg_pkg::Z_REP_IDX*8 +: 8])
	); // RQ1 RQ7

	assign xy_repetition_count =
		config_bytes[magreg_pkg::XY_REP_IDX*8 +: 8]; // RQ9
	assign z_repetition_count  =
		config_bytes[magreg_pkg::Z_REP_IDX*8 +: 8]; // RQ7

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// the answer is built from the stored bytes before this edge's write lands,
	// so a read and a write to one byte in the same cycle return the old value;
	// the host must take the answer in the cycle it stands
	logic [7:0] rdata_d;
	logic       drive_d;

	always_comb begin
		rdata_d = magreg_pkg::READ_FILL;
		drive_d = 1'b1;
		case (cls)
			magreg_pkg::CLS_ID: begin
				rdata_d = magreg_pkg::DEVICE_ID;
			end
			magreg_pkg::CLS_STATUS: begin
				rdata_d = status_bytes[st_off[3:0]*8 +: 8];
			end
			magreg_pkg::CLS_RW: begin
				rdata_d = config_bytes[rw_off[2:0]*8 +: 8]; // RQ1
			end
			magreg_pkg::CLS_RSVD: begin
				// reserved: no content, data line released
				drive_d = 1'b0; // RQ5 RQ8
			end
			magreg_pkg::CLS_NONE: begin
				drive_d = 1'b0;
			end
			default: begin
				drive_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rsp_q <= '0;
		end else begin
			rsp_q.valid <= req.rd;
			rsp_q.drive <= req.rd & drive_d;
			rsp_q.data  <= req.rd ? rdata_d : magreg_pkg::READ_FILL;
		end
	end

	// ------------------------------------------------------------
	// write acknowledge
	// ------------------------------------------------------------
	// wr_done answers every write; wr_taken tells the host whether
	// anything was stored, which a silent drop otherwise hides
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_done_q <= 1'b0;
		end else begin
			wr_done_q <= req.wr;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_taken_q <= 1'b0;
		end else begin
			wr_taken_q <= req.wr && cls == magreg_pkg::CLS_RW; // RQ6
		end
	end

endmodule

// *** test/magreg_assertions.sv ***
`timescale 1ns/1ps
module magreg_assertions (
	input wire logic                 clk,
	input wire logic                 nrst,
	input wire magreg_pkg::reg_req_t req,
	input wire magreg_pkg::reg_rsp_t rsp_q,
	input wire logic                 wr_done_q,
	input wire logic                 wr_taken_q,
	input wire logic [63:0]          config_bytes,
	input wire logic [7:0]           xy_repetition_count,
	input wire logic [7:0]           z_repetition_count
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	AST_WR_DONE: assert property (req.wr |=> wr_done_q)
		else $error("write not acknowledged");
	AST_RD_VALID: assert property (req.rd |=> rsp_q.valid)
		else $error("read not answered");
	AST_RW_TAKEN: assert property (req.wr && req.addr inside {[8'h4B:8'h52]} |=> wr_taken_q)
		else $error("writable byte not stored");
	AST_RO_DROP: assert property (req.wr && req.addr inside {[8'h40:8'h4A]}
		|=> !wr_taken_q && $stable(config_bytes)) else $error("read-only write stored");
	AST_RSVD_DROP: assert property (req.wr && !(req.addr inside {[8'h40:8'h52]})
		|=> !wr_taken_q && $stable(config_bytes)) else $error("reserved write stored");
	AST_RSVD_BITS: assert property (req.wr && req.addr == 8'h4B |=> config_bytes[6:3] == 4'h0)
		else $error("fixed bits changed");
	AST_Z_STORE: assert property (req.wr && req.addr == 8'h52
		|=> z_repetition_count == $past(req.wdata)) else $error("z count not stored");
	AST_XY_STORE: assert property (req.wr && req.addr == 8'h51
		|=> xy_repetition_count == $past(req.wdata)) else $error("xy count not stored");
	AST_RSVD_READ: assert property (req.rd && !(req.addr inside {8'h40, [8'h42:8'h52]})
		|=> !rsp_q.drive && rsp_q.data == 8'h00) else $error("reserved read driven");
endmodule

bind magnetometer_register_space magreg_assertions u_chk (.clk, .nrst, .req, .rsp_q, .wr_done_q,
	.wr_taken_q, .config_bytes, .xy_repetition_count, .z_repetition_count);

// *** test/host_model.sv ***
`timescale 1ns/1ps
module host_model (
	input  wire logic            clk,
	output magreg_pkg::reg_req_t req
);
	initial req = '0;
	task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{w, r, a, d};
	endtask
	// released lines flip, so a stale address or data byte can never pass for a fresh one
	task automatic idle();
		@(posedge clk);
		#1 req = '{1'b0, 1'b0, ~req.addr, ~req.wdata};
	endtask
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic                 clk = 1'b0;
	logic                 nrst = 1'b0;
	magreg_pkg::reg_req_t req;
	magreg_pkg::reg_rsp_t rsp_q;
	logic                 wr_done_q;
	logic                 wr_taken_q;
	logic [63:0]          config_bytes;
	logic [7:0]           xy_count;
	logic [7:0]           z_count;
	logic [71:0]          status_bytes = 72'h998877665544332211;
	int                   failures = 0;
	int                   tests_run = 0;
	// address, write data, stored, driven, read-back
	logic [25:0]          rows [13] = '{{8'h4B, 8'hFF, 2'b11, 8'h87}, {8'h51, 8'h5A, 2'b11, 8'h5A},
		{8'h52, 8'hC3, 2'b11, 8'hC3}, {8'h40, 8'hFF, 2'b01, magreg_pkg::DEVICE_ID},
		{8'h42, 8'hFF, 2'b01, 8'h11}, {8'h4A, 8'hFF, 2'b01, 8'h99}, {8'h41, 8'h33, 2'b00, 8'h00},
		{8'h53, 8'h44, 2'b00, 8'h00}, {8'h71, 8'h55, 2'b00, 8'h00}, {8'h72, 8'h66, 2'b00, 8'h00},
		{8'h3F, 8'h77, 2'b00, 8'h00}, {8'h4E, 8'h5A, 2'b11, 8'h5A},
		{8'h46, 8'hFF, 2'b01, 8'h55}};
	always #5 clk = ~clk;
	host_model host (.clk(clk), .req(req));
	magnetometer_register_space uut (.clk(clk), .nrst(nrst), .req(req),
		.status_bytes(status_bytes), .rsp_q(rsp_q), .wr_done_q(wr_done_q),
		.wr_taken_q(wr_taken_q), .config_bytes(config_bytes),
		.xy_repetition_count(xy_count), .z_repetition_count(z_count));
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			failures++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic stop_test();
		if (failures == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#5000;
		failures++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		foreach (rows[i]) begin
			host.xfer(1'b1, 1'b0, rows[i][25:18], rows[i][17:10]);
			host.idle();
			chk(wr_done_q === 1'b1 && wr_taken_q === rows[i][9], "write store");
			host.xfer(1'b0, 1'b1, rows[i][25:18], 8'h00);
			host.idle();
			chk(rsp_q.drive === rows[i][8] && rsp_q.data === rows[i][7:0], "read");
			chk(rsp_q.valid === 1'b1, "read answered");
		end
		// read in the cycle of a write sees the old byte; next write follows back to back
		host.xfer(1'b1, 1'b1, 8'h52, 8'h3C);
		host.xfer(1'b1, 1'b0, 8'h51, 8'h77);
		chk(rsp_q.data === 8'hC3 && z_count === 8'h3C, "same cycle");
		host.xfer(1'b0, 1'b1, 8'h51, 8'h00);
		host.idle();
		chk(rsp_q.data === 8'h77 && xy_count === 8'h77, "xy count");
		@(posedge clk);
		#1 nrst = 1'b0;
		#1 chk(config_bytes === 64'h00000000073F0601 && z_count === 8'h00, "reset");
		chk(rsp_q === '0 && wr_done_q === 1'b0 && wr_taken_q === 1'b0, "reset outputs");
		@(posedge clk);
		#1 nrst = 1'b1;
		host.xfer(1'b0, 1'b1, magreg_pkg::Z_REP_ADDR, 8'h00);
		host.idle();
		chk(rsp_q.valid === 1'b1 && rsp_q.data === magreg_pkg::Z_REP_RESET, "z after reset");
		chk(wr_done_q === 1'b0 && xy_count === magreg_pkg::XY_REP_RESET, "xy after reset");
		stop_test();
	end
endmodule
